// [hw/cdg_pkg.sv]
// Purpose : Shared constants and types for the discharge gating block
// Assumes : APB slave, 32-bit data, 100 MHz core clock
// Notes   : Offsets are byte addresses
package cdg_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned CELLS_DEF  = 15;
  localparam int unsigned GROUPS_DEF = 5;
  localparam int unsigned ACC_W      = 32;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_DCHG   = 8'h04;
  localparam logic [7:0] OFS_CMD    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_RESULT = 8'h10;

  // CTRL fields
  localparam int unsigned CTRL_PERMIT_BIT = 0;
  localparam int unsigned CTRL_OSR_LSB    = 1;
  localparam logic [2:0]  CTRL_RST        = 3'h0;

  // CMD fields (write one to issue)
  localparam int unsigned CMD_CONVERT_BIT = 0;
  localparam int unsigned CMD_SUSPEND_BIT = 1;
  localparam int unsigned CMD_RESUME_BIT  = 2;

  // STATUS fields
  localparam int unsigned STS_SUSP_BIT  = 16;
  localparam int unsigned STS_BUSY_BIT  = 17;
  localparam int unsigned STS_GRP_LSB   = 18;
  localparam int unsigned STS_PLAT_BIT  = 21;
  localparam int unsigned STS_RVAL_BIT  = 22;

  // Decimation shift per oversampling select: 64, 128, 256, 512
  localparam logic [3:0] OSR_SHIFT_BASE = 4'h6;

  typedef enum logic [1:0] {
    CDG_ST_IDLE = 2'b00,
    CDG_ST_CONV = 2'b01
  } cdg_state_t;

  typedef struct packed {
    logic [1:0] osr_sel;
    logic       permit;
  } cdg_ctrl_t;

  typedef struct packed {
    logic convert;
    logic suspend;
    logic resume;
  } cdg_cmd_t;

endpackage : cdg_pkg

// [hw/cdg_third_order_decimator.sv]
// Purpose : Third-order sinc decimator behind the delta-sigma modulator
// Assumes : One modulator bit per enabled clock
// Notes   : Ratio is 2**(6+osr_sel)
`timescale 1ns/1ps
module cdg_decim3
  import cdg_pkg::*;
(
  input  wire logic             mclk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic             bit_i,
  input  wire logic [1:0]       osr_sel_i,
  output logic [ACC_W-1:0]      result_o,
  output logic                  valid_o
);

  logic [ACC_W-1:0] i1_ff, i2_ff, i3_ff, c1_ff, c2_ff, c3_ff;
  logic [ACC_W-1:0] nxt_i1, nxt_i2, nxt_i3, nxt_c1, nxt_c2, nxt_c3;
  logic [ACC_W-1:0] d1, d2, d3;
  logic [ACC_W-1:0] res_ff, nxt_res;
  logic [9:0]       cnt_ff, nxt_cnt;
  logic             val_ff, nxt_val;
  logic [9:0]       last;

  // ----------------------------------------------------------------
  // Integrators at modulator rate, combs at output rate
  // ----------------------------------------------------------------
  always_comb begin
    last    = 10'((11'h1 << (OSR_SHIFT_BASE + 4'(osr_sel_i))) - 11'h1);
    nxt_i1  = i1_ff;
    nxt_i2  = i2_ff;
    nxt_i3  = i3_ff;
    nxt_c1  = c1_ff;
    nxt_c2  = c2_ff;
    nxt_c3  = c3_ff;
    nxt_res = res_ff;
    nxt_cnt = cnt_ff;
    nxt_val = 1'b0;
    d1      = i3_ff - c1_ff;
    d2      = d1 - c2_ff;
    d3      = d2 - c3_ff;
    if (!run_i) begin
      nxt_i1  = '0;
      nxt_i2  = '0;
      nxt_i3  = '0;
      nxt_c1  = '0;
      nxt_c2  = '0;
      nxt_c3  = '0;
      nxt_cnt = '0;
    end else begin
      nxt_i1  = i1_ff + ACC_W'(bit_i);
      nxt_i2  = i2_ff + i1_ff;
      nxt_i3  = i3_ff + i2_ff;
      nxt_cnt = (cnt_ff >= last) ? 10'h000 : cnt_ff + 10'h001;
      if (cnt_ff >= last) begin
        nxt_c1  = i3_ff;
        nxt_c2  = d1;
        nxt_c3  = d2;
        nxt_res = d3;
        nxt_val = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      i1_ff  <= '0;
      i2_ff  <= '0;
      i3_ff  <= '0;
      c1_ff  <= '0;
      c2_ff  <= '0;
      c3_ff  <= '0;
      res_ff <= '0;
      cnt_ff <= '0;
      val_ff <= 1'b0;
    end else begin
      i1_ff  <= nxt_i1;
      i2_ff  <= nxt_i2;
      i3_ff  <= nxt_i3;
      c1_ff  <= nxt_c1;
      c2_ff  <= nxt_c2;
      c3_ff  <= nxt_c3;
      res_ff <= nxt_res;
      cnt_ff <= nxt_cnt;
      val_ff <= nxt_val;
    end
  end

  assign result_o = res_ff;
  assign valid_o  = val_ff;

endmodule : cdg_decim3

// [hw/cdg_sdrive.sv]
// Purpose : Registered digital drive stage for the discharge outputs
// Assumes : Pins are push-pull digital outputs
// Notes   : High level turns a discharge switch on
`timescale 1ns/1ps
module cdg_sdrive #(
  parameter int unsigned N = 15
) (
  input  wire logic         mclk_i,
  input  wire logic         rst_i,
  input  wire logic [N-1:0] on_i,
  output logic [N-1:0]      pin_o
);

  logic [N-1:0] pin_ff;
  logic [N-1:0] nxt_pin;

  always_comb begin
    nxt_pin = on_i;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_ff <= '0;
    end else begin
      pin_ff <= nxt_pin;
    end
  end

  assign pin_o = pin_ff;

endmodule : cdg_sdrive

// [hw/cdg_gating.sv]
// Purpose : Discharge output gating during cell conversions, APB registers
// Assumes : Sequencer on the same clock reports the group under conversion
// Notes   : Calibration periods reuse the measurement group numbering
`timescale 1ns/1ps
// Contract
// - Permit set at convert command: outputs hold their state all conversion unless a suspend turns them off.
// - Permit clear: output off while its own or adjacent group converts.
// - Scheduled-off output is forced off whatever its enable bit says.
// - Scheduled-on output stays on only if on before the command.
// - Suspend turns all outputs off at once, stored enables kept.
// - Resume turns back on the stored enables, or during a conversion what the snapshot allows.
// - Modulator is followed by a third-order sinc decimator with selectable ratio.
// - Discharge outputs also serve as plain digital drive outputs.
// - Permit clear: output n off for group (n mod 5)+1 and neighbours.
module cdg_gating
  import cdg_pkg::*;
#(
  parameter int unsigned N_CELLS  = CELLS_DEF,
  parameter int unsigned N_GROUPS = GROUPS_DEF
) (
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  // APB slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [7:0]          paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic                     pready_o,
  output logic [31:0]              prdata_o,
  output logic                     pslverr_o,
  // Conversion sequencer
  input  wire logic [2:0]          seq_group_i,
  input  wire logic                seq_cal_i,
  input  wire logic                seq_done_i,
  input  wire logic                mod_bit_i,
  output logic                     seq_start_o,
  // Discharge pins
  output logic [N_CELLS-1:0]       dis_pin_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (N_CELLS < 1 || N_CELLS > 16 || N_GROUPS < 3 || N_GROUPS > 7) begin : g_chk
    $error("cdg_gating: unsupported cell or group count");
  end

  // Pin bits must stay below the status flags
  if (N_CELLS > STS_SUSP_BIT) begin : g_sts
    $error("cdg_gating: pin bits overlap status flags");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Outputs that must be off while group grp (1-based) converts
  function automatic logic [N_CELLS-1:0] off_mask(input logic [2:0] grp);
    logic [N_CELLS-1:0] m;
    int unsigned        own;
    int unsigned        cur;
    m = '0;
    cur = (grp == 3'h0) ? 0 : int'(grp) - 1;
    for (int unsigned i = 0; i < N_CELLS; i++) begin
      own = i % N_GROUPS;
      if (cur == own || cur == (own + 1) % N_GROUPS ||
          cur == (own + N_GROUPS - 1) % N_GROUPS) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : off_mask

  function automatic logic [31:0] widen(input logic [N_CELLS-1:0] v);
    logic [31:0] w;
    w = '0;
    w[N_CELLS-1:0] = v;
    return w;
  endfunction : widen

  // Offsets that map to a register
  function automatic logic reg_hit(input logic [7:0] addr);
    return (addr == OFS_CTRL)   || (addr == OFS_DCHG) ||
           (addr == OFS_CMD)    || (addr == OFS_STATUS) ||
           (addr == OFS_RESULT);
  endfunction : reg_hit

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic      setup;
  logic      wr_acc;
  logic      hit;
  logic      cmd_hit;
  cdg_cmd_t  cmd;

  assign setup    = psel_i & ~penable_i;
  assign wr_acc   = psel_i & penable_i & pwrite_i;
  assign cmd_hit  = wr_acc & (paddr_i == OFS_CMD);
  assign pready_o = 1'b1;

  always_comb begin
    hit         = reg_hit(paddr_i);
    cmd.convert = cmd_hit & pwdata_i[CMD_CONVERT_BIT];
    cmd.suspend = cmd_hit & pwdata_i[CMD_SUSPEND_BIT];
    cmd.resume  = cmd_hit & pwdata_i[CMD_RESUME_BIT];
  end

  // ----------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------
  cdg_ctrl_t          ctrl_ff, nxt_ctrl;
  logic [N_CELLS-1:0] dchg_ff, nxt_dchg;
  cdg_state_t         st_ff, nxt_st;
  logic               plat_ff, nxt_plat;
  logic [N_CELLS-1:0] pre_ff, nxt_pre;
  logic               susp_ff, nxt_susp;
  logic               start_ff, nxt_start;
  logic [N_CELLS-1:0] on_now;
  logic [N_CELLS-1:0] on_nxt;

  always_comb begin
    nxt_ctrl  = ctrl_ff;
    nxt_dchg  = dchg_ff;
    nxt_st    = st_ff;
    nxt_plat  = plat_ff;
    nxt_pre   = pre_ff;
    nxt_susp  = susp_ff;
    nxt_start = 1'b0;
    if (wr_acc && paddr_i == OFS_CTRL) begin
      nxt_ctrl.permit  = pwdata_i[CTRL_PERMIT_BIT];
      nxt_ctrl.osr_sel = pwdata_i[CTRL_OSR_LSB +: 2];
    end
    // Stored enables are never touched by suspend or resume
    if (wr_acc && paddr_i == OFS_DCHG) begin
      nxt_dchg = pwdata_i[N_CELLS-1:0];
    end
    // Suspend outranks resume in the same write; persists otherwise
    if (cmd.resume) begin
      nxt_susp = 1'b0;
    end
    if (cmd.suspend) begin
      nxt_susp = 1'b1;
    end
    case (st_ff)
      CDG_ST_IDLE: begin
        if (cmd.convert) begin
          nxt_st    = CDG_ST_CONV;
          nxt_plat  = ctrl_ff.permit;
          // Snapshot counts suspended outputs as off
          nxt_pre   = on_now;
          nxt_start = 1'b1;
        end
      end
      CDG_ST_CONV: begin
        // A convert written while busy is dropped
        if (seq_done_i) begin
          nxt_st = CDG_ST_IDLE;
        end
      end
      default: begin
        nxt_st = CDG_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_ff  <= CTRL_RST;
      dchg_ff  <= '0;
      st_ff    <= CDG_ST_IDLE;
      plat_ff  <= 1'b0;
      pre_ff   <= '0;
      susp_ff  <= 1'b0;
      start_ff <= 1'b0;
    end else begin
      ctrl_ff  <= nxt_ctrl;
      dchg_ff  <= nxt_dchg;
      st_ff    <= nxt_st;
      plat_ff  <= nxt_plat;
      pre_ff   <= nxt_pre;
      susp_ff  <= nxt_susp;
      start_ff <= nxt_start;
    end
  end

  assign seq_start_o = start_ff;

  // ----------------------------------------------------------------
  // Output gating
  // ----------------------------------------------------------------
  // seq_cal_i needs no branch: calibration uses the same group pattern
  always_comb begin
    if (susp_ff) begin
      on_now = '0;
    end else if (st_ff != CDG_ST_CONV) begin
      on_now = dchg_ff;
    end else if (plat_ff) begin
      on_now = pre_ff;
    end else begin
      on_now = pre_ff & ~off_mask(seq_group_i);
    end
    // Suspend acts from the very next edge; resume does too outside a conversion, one edge later during one
    if (cmd.suspend) begin
      on_nxt = '0;
    end else if (cmd.resume && st_ff != CDG_ST_CONV) begin
      on_nxt = dchg_ff;
    end else begin
      on_nxt = on_now;
    end
  end

  cdg_sdrive #(
    .N      (N_CELLS)
  ) u_drive (
    .mclk_i (mclk_i),
    .rst_i  (rst_i),
    .on_i   (on_nxt),
    .pin_o  (dis_pin_o)
  );

  // ----------------------------------------------------------------
  // Decimator
  // ----------------------------------------------------------------
  logic [ACC_W-1:0] res;
  logic             res_val;
  logic             rval_ff, nxt_rval;

  cdg_decim3 u_decim (
    .mclk_i    (mclk_i),
    .rst_i     (rst_i),
    .run_i     (st_ff == CDG_ST_CONV),
    .bit_i     (mod_bit_i),
    .osr_sel_i (ctrl_ff.osr_sel),
    .result_o  (res),
    .valid_o   (res_val)
  );

  // Result-valid flag: new result sets, reading RESULT clears, set wins
  always_comb begin
    nxt_rval = rval_ff;
    if (setup && !pwrite_i && paddr_i == OFS_RESULT) begin
      nxt_rval = 1'b0;
    end
    if (res_val) begin
      nxt_rval = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rval_ff <= 1'b0;
    end else begin
      rval_ff <= nxt_rval;
    end
  end

  // ----------------------------------------------------------------
  // Read data, captured in the setup cycle
  // ----------------------------------------------------------------
  logic [31:0] rd_ff, nxt_rd;
  logic        err_ff, nxt_err;
  logic [31:0] sts;

  // Status image: pin states low, flags above them
  always_comb begin
    sts                = widen(dis_pin_o);
    sts[STS_SUSP_BIT]  = susp_ff;
    sts[STS_BUSY_BIT]  = (st_ff == CDG_ST_CONV);
    sts[STS_GRP_LSB +: 3] = seq_group_i;
    sts[STS_PLAT_BIT]  = plat_ff;
    sts[STS_RVAL_BIT]  = rval_ff;
    nxt_rd  = rd_ff;
    nxt_err = err_ff;
    if (setup) begin
      nxt_err = ~hit;
      case (paddr_i)
        OFS_CTRL:   nxt_rd = {29'h0, ctrl_ff.osr_sel, ctrl_ff.permit};
        OFS_DCHG:   nxt_rd = widen(dchg_ff);
        OFS_STATUS: nxt_rd = sts;
        OFS_RESULT: nxt_rd = res;
        default:    nxt_rd = 32'h0;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_ff  <= 32'h0;
      err_ff <= 1'b0;
    end else begin
      rd_ff  <= nxt_rd;
      err_ff <= nxt_err;
    end
  end

  assign prdata_o  = rd_ff;
  assign pslverr_o = err_ff & psel_i & penable_i;

endmodule : cdg_gating

// [testbench/cdg_gating_chk.sv]
// Purpose: Port assertions for the discharge gating block
// Assumes: Sequencer holds each group for several cycles
// Notes  : Helpers mirror CTRL, DCHG and CMD writes
`timescale 1ns/1ps
module cdg_gating_chk
  import cdg_pkg::*;
#(
  parameter int unsigned N_CELLS  = CELLS_DEF,
  parameter int unsigned N_GROUPS = GROUPS_DEF
) (
  input wire logic               mclk_i,
  input wire logic               rst_i,
  input wire logic               psel_i,
  input wire logic               penable_i,
  input wire logic               pwrite_i,
  input wire logic [7:0]         paddr_i,
  input wire logic [31:0]        pwdata_i,
  input wire logic [2:0]         seq_group_i,
  input wire logic               seq_done_i,
  input wire logic               seq_start_o,
  input wire logic [N_CELLS-1:0] dis_pin_o
);
  logic               wr, cmd, go, conv_ff, perm_ff, plat_ff, susp_ff;
  logic [N_CELLS-1:0] dchg_ff, snap_ff;
  logic [2:0]         quiet_ff;

  assign wr  = psel_i & penable_i & pwrite_i;
  assign cmd = wr & (paddr_i == OFS_CMD);
  assign go  = cmd & pwdata_i[CMD_CONVERT_BIT];

  // Outputs forced off while their own or a neighbouring group converts
  function automatic logic [N_CELLS-1:0] gmask(input logic [2:0] grp);
    int g;
    int d;
    gmask = '0;
    g = (grp == 3'h0) ? 1 : int'(grp);
    for (int n = 0; n < N_CELLS; n++) begin
      d = (g - n % N_GROUPS - 1 + N_GROUPS) % N_GROUPS;
      gmask[n] = d == 0 || d == 1 || d == N_GROUPS - 1;
    end
  endfunction : gmask

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      conv_ff  <= 1'b0;
      perm_ff  <= 1'b0;
      plat_ff  <= 1'b0;
      susp_ff  <= 1'b0;
      dchg_ff  <= '0;
      snap_ff  <= '0;
      quiet_ff <= 3'h0;
    end else begin
      quiet_ff <= wr ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
      if (wr && paddr_i == OFS_CTRL) perm_ff <= pwdata_i[CTRL_PERMIT_BIT];
      if (wr && paddr_i == OFS_DCHG) dchg_ff <= pwdata_i[N_CELLS-1:0];
      if (go && !conv_ff) begin
        plat_ff <= perm_ff;
        snap_ff <= susp_ff ? '0 : dchg_ff;
      end
      if (seq_start_o) conv_ff <= 1'b1;
      else if (seq_done_i) conv_ff <= 1'b0;
      if (cmd && pwdata_i[CMD_SUSPEND_BIT]) susp_ff <= 1'b1;
      else if (cmd && pwdata_i[CMD_RESUME_BIT]) susp_ff <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  AST_START: assert property (go && !conv_ff |=> seq_start_o ##1 !seq_start_o)
    else $error("convert write gave no single start pulse");
  AST_START_SRC: assert property ($rose(seq_start_o) |-> $past(go))
    else $error("start pulse without convert write");
  AST_SUSP_OFF: assert property (cmd && pwdata_i[CMD_SUSPEND_BIT] |-> ##2 dis_pin_o == '0)
    else $error("pins not off after suspend");
  AST_SUSP_HOLD: assert property (susp_ff && $past(susp_ff, 3) |-> dis_pin_o == '0)
    else $error("pin on while suspended");
  AST_MASK: assert property (conv_ff && !plat_ff && seq_group_i == $past(seq_group_i, 3)
    |-> (dis_pin_o & gmask(seq_group_i)) == '0)
    else $error("pin on beside converting group");
  AST_SUBSET: assert property (conv_ff |-> (dis_pin_o & ~snap_ff) == '0)
    else $error("pin on that was off before convert");
  AST_STABLE: assert property (conv_ff && $past(conv_ff) && plat_ff && quiet_ff >= 3'h3
    |-> $stable(dis_pin_o))
    else $error("pins moved during permitted conversion");
  AST_IDLE: assert property (quiet_ff >= 3'h3 && !susp_ff && !conv_ff && !$past(conv_ff)
    && !$past(conv_ff, 2) |-> dis_pin_o == dchg_ff)
    else $error("idle pins differ from enables");

  cover property (conv_ff && !plat_ff && seq_group_i == 3'h5);
  cover property (conv_ff && susp_ff);
  cover property ($fell(susp_ff) && dchg_ff != '0);
endmodule : cdg_gating_chk

bind cdg_gating cdg_gating_chk #(.N_CELLS(N_CELLS), .N_GROUPS(N_GROUPS)) u_chk (
  .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .seq_group_i(seq_group_i),
  .seq_done_i(seq_done_i), .seq_start_o(seq_start_o), .dis_pin_o(dis_pin_o));

// [testbench/cdg_seq_model.sv]
// Purpose: Conversion sequencer model facing the gating block
// Assumes: Five measured groups, then the same five calibrated
// Notes  : HOLD sets cycles per group
`timescale 1ns/1ps
module cdg_seq_model #(
  parameter int unsigned HOLD = 30
) (
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  input  wire logic  start_i,
  output logic [2:0] group_o,
  output logic       cal_o,
  output logic       done_o,
  output logic       bit_o
);
  logic       run_ff;
  logic [3:0] ph_ff;
  logic [7:0] cnt_ff;

  assign group_o = run_ff ? 3'(ph_ff % 4'h5 + 4'h1) : 3'h0;
  assign cal_o   = run_ff && ph_ff > 4'h4;

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      run_ff <= 1'b0;
      ph_ff  <= 4'h0;
      cnt_ff <= 8'h00;
      done_o <= 1'b0;
      bit_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      // Full-scale modulator stream: a settled result equals the filter gain
      bit_o  <= 1'b1;
      if (!run_ff) begin
        run_ff <= start_i;
        ph_ff  <= 4'h0;
        cnt_ff <= 8'h00;
      end else if (cnt_ff != 8'(HOLD - 1)) begin
        cnt_ff <= cnt_ff + 8'h01;
      end else begin
        cnt_ff <= 8'h00;
        ph_ff  <= ph_ff + 4'h1;
        run_ff <= ph_ff != 4'h9;
        done_o <= ph_ff == 4'h9;
      end
    end
  end
endmodule : cdg_seq_model

// [testbench/cdg_gating_bench.sv]
// Purpose: Self-checking bench for the discharge gating block
// Assumes: Sequencer model answers every start pulse
// Notes  : Expected pin sets per group come from a fixed table
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module cdg_gating_bench
  import cdg_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, start, cal, done, mbit;
  logic [2:0]  grp;
  logic [14:0] pins;
  logic [14:0] tbl [1:5] = '{15'h318c, 15'h6318, 15'h4631, 15'h0c63, 15'h18c6};
  int          failures = 0;
  int          cmp_count = 0;

  always #5 mclk = ~mclk;

  cdg_gating dut (.mclk_i(mclk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .seq_group_i(grp), .seq_cal_i(cal), .seq_done_i(done),
    .mod_bit_i(mbit), .seq_start_o(start), .dis_pin_o(pins));
  cdg_seq_model #(.HOLD(30)) seq (.mclk_i(mclk), .rst_i(rst), .start_i(start),
    .group_o(grp), .cal_o(cal), .done_o(done), .bit_o(mbit));

  task automatic end_sim();
    if (failures == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    pen <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge mclk);
  endtask : apb

  task automatic wait_ph(input logic c, input logic [2:0] g);
    int n;
    n = 0;
    while (!(grp === g && cal === c) && n < 1000) begin
      n++;
      @(posedge mclk);
    end
    if (n >= 1000) failures++;
    repeat (4) @(posedge mclk);
  endtask : wait_ph

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 1000) begin
      n++;
      @(posedge mclk);
    end
    if (n >= 1000) failures++;
    repeat (3) @(posedge mclk);
  endtask : wait_done

  // Enables rewritten just after the command must not reach the pins
  task automatic conv_run(input logic p, input logic [14:0] d);
    apb(1'b1, OFS_DCHG, {17'h0, d});
    apb(1'b1, OFS_CTRL, {31'h0, p});
    apb(1'b1, OFS_CMD, 32'h1);
    apb(1'b1, OFS_DCHG, 32'h7fff);
    for (int c = 0; c < 2; c++) begin
      for (int g = 1; g < 6; g++) begin
        wait_ph(c[0], g[2:0]);
        `CHK(pins, p ? d : d & tbl[g])
      end
    end
    wait_done();
    `CHK(pins, 15'h7fff)
  endtask : conv_run

  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    apb(1'b1, OFS_DCHG, 32'h7fff);
    repeat (3) @(posedge mclk);
    `CHK(pins, 15'h7fff)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(err, 1'b1)
    // Settling pause before the first full conversion
    repeat (6) @(posedge mclk);
    conv_run(1'b0, 15'h7fff);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd, 32'h0040_7fff)
    apb(1'b0, OFS_RESULT, 32'h0);
    // Settled full-scale result is the ratio cubed
    `CHK(rd, 32'h1 << (3 * OSR_SHIFT_BASE))
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[22], 1'b0)
    conv_run(1'b0, 15'h0421);
    conv_run(1'b1, 15'h5555);
    apb(1'b1, OFS_DCHG, 32'h2aaa);
    apb(1'b1, OFS_CMD, 32'h2);
    repeat (2) @(posedge mclk);
    `CHK(pins, 15'h0)
    apb(1'b0, OFS_DCHG, 32'h0);
    `CHK(rd, 32'h2aaa)
    `CHK(err, 1'b0)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[16], 1'b1)
    apb(1'b1, OFS_CMD, 32'h1);
    wait_ph(1'b0, 3'h3);
    `CHK(pins, 15'h0)
    wait_done();
    `CHK(pins, 15'h0)
    apb(1'b1, OFS_CMD, 32'h4);
    repeat (2) @(posedge mclk);
    `CHK(pins, 15'h2aaa)
    apb(1'b1, OFS_CMD, 32'h2);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK(pins, 15'h0)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[16], 1'b0)
    end_sim();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    end_sim();
  end
endmodule : cdg_gating_bench
